// ===== design/sirq_router.sv
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [RULE1] each peripheral line routes to one core level by software code field
// [RULE2] eight ids per assignment register, seven registers for ids 0..55
// [RULE3] reset: ids 0-10 and 47 use code 0, level 7
// [RULE4] reset: ids 12-13 code 1 level 8; ids 14-19 code 2 level 9
// [RULE5] reset: ids 20-25, 48, 51-55 code 3, level 10
// [RULE6] reset: 26-30 code 4, 32-41 code 5, 42-46 code 6
// [RULE7] mask, status and wake pairs of 32-bit registers, low and high ids
// [RULE8] set system mask bit forwards the line, clear blocks it
// [RULE9] status bit reads the live level of the peripheral line
// [RULE10] wake-enabled event while core idle raises a wake request
// [RULE11] core stage has 16-bit latch, mask and active registers
// [RULE12] latch sets on detected rising edge, clears when active sets
// [RULE13] software latch writes only land where core mask is clear
// [RULE14] set core mask lets a latched event be serviced
// [RULE15] global enable gates all general-purpose events
// [RULE16] active bit set for every active or nested event
// [RULE17] after active sets, the next rising edge is latched again
// [RULE18] shared inputs accept pulses before or during servicing
// [RULE19] edge to active takes at least three clocks
// [RULE20] nine general-purpose levels 7..15, lower number wins
// [RULE21] reserved ids never assert, status reads zero
module sirq_router (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [63:0] periph_irq,
	input wire logic core_idle,
	input wire logic global_irq_on_instr,
	input wire logic global_irq_off_instr,
	input wire logic pipe_accept,
	input wire logic [15:0] evt_retire,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic wake_req,
	output logic irq_req,
	output logic [3:0] irq_level
);
	// ==========================================================
	// input capture
	logic [63:0] line_sync;
	logic [15:0] retire_sync;
	logic [1:0] ctl_sync;
	sirq_sync #(.W(64)) u_sync_irq (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.d(periph_irq),
		.q(line_sync)
	);
	sirq_sync #(.W(16)) u_sync_ret (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.d(evt_retire),
		.q(retire_sync)
	);
	sirq_sync #(.W(2)) u_sync_ctl (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.d({core_idle, pipe_accept}),
		.q(ctl_sync)
	);
	wire idle_s = ctl_sync[1];
	wire accept_s = ctl_sync[0];

	// ==========================================================
	// registers
	logic [31:0] mask_lo_reg;
	logic [31:0] mask_hi_reg;
	logic [31:0] wake_lo_reg;
	logic [31:0] wake_hi_reg;
	logic [31:0] assign_reg [sirq_pkg::NUM_ASSIGN];
	logic [15:0] cmask_reg;
	logic gie_reg;
	logic [15:0] latch_q;
	logic [15:0] active_q;
	logic ack_reg;

	// ==========================================================
	// bus decode
	sirq_pkg::sirq_req_t req;
	assign req = '{addr: avs_address, read: avs_read, write: avs_write,
		wdata: avs_writedata};
	wire take_req = (req.read | req.write) & avs_waitrequest & ~ack_reg;
	wire wr_go = req.write & take_req;
	wire wr_mask_lo = wr_go && req.addr == sirq_pkg::OFF_MASK_LO;
	wire wr_mask_hi = wr_go && req.addr == sirq_pkg::OFF_MASK_HI;
	wire wr_wake_lo = wr_go && req.addr == sirq_pkg::OFF_WAKE_LO;
	wire wr_wake_hi = wr_go && req.addr == sirq_pkg::OFF_WAKE_HI;
	wire wr_latch = wr_go && req.addr == sirq_pkg::OFF_LATCH;
	wire wr_cmask = wr_go && req.addr == sirq_pkg::OFF_CMASK;
	wire asg_hit = req.addr >= sirq_pkg::OFF_ASSIGN0 &&
		req.addr < sirq_pkg::OFF_LATCH;
	wire [5:0] asg_off = req.addr - sirq_pkg::OFF_ASSIGN0;
	wire [2:0] asg_idx = asg_off[4:2];

	// ==========================================================
	// system stage
	wire [63:0] live = line_sync & sirq_pkg::VALID_IDS; // see [RULE21]
	wire [63:0] status = live; // see [RULE9]
	wire [63:0] fwd = live & {mask_hi_reg, mask_lo_reg}; // see [RULE8]
	wire [63:0] wake_hit = live & {wake_hi_reg, wake_lo_reg};
	logic [15:0] gp_in;
	always_comb begin
		logic [3:0] code;
		code = 4'h0;
		gp_in = 16'h0000;
		for (int i = 0; i < sirq_pkg::NUM_ROUTED; i++) begin
			// see [RULE2]
			code = assign_reg[i / sirq_pkg::IDS_PER_ASSIGN][(i % 8) * 4 +: 4];
			if (fwd[i] && code < 4'(sirq_pkg::NUM_LEVELS))
				gp_in[4'(code) + 4'(sirq_pkg::FIRST_LEVEL)] = 1'b1; // see [RULE1]
		end
	end

	// ==========================================================
	// core stage, one cell per general-purpose level
	// lowest-numbered pending unmasked level gets the pipeline grant
	logic [15:0] grant;
	logic [3:0] win_level;
	logic win_any;
	always_comb begin
		grant = 16'h0000;
		win_level = 4'h0;
		win_any = 1'b0;
		for (int l = 15; l >= sirq_pkg::FIRST_LEVEL; l--) begin
			if (latch_q[l] && cmask_reg[l] && gie_reg) begin // see [RULE14]
				win_level = 4'(l); // see [RULE20]
				win_any = 1'b1;
			end
		end
		if (win_any && accept_s)
			grant[win_level] = 1'b1;
	end

	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_cell
			if (g >= sirq_pkg::FIRST_LEVEL) begin : g_gp
				sirq_edge_latch u_cell (
					.sys_clk(sys_clk),
					.rst_n(rst_n),
					.evt_in(gp_in[g]),
					.mask_bit(cmask_reg[g]),
					.gie(gie_reg), // see [RULE15]
					.grant(grant[g]),
					.retire(retire_sync[g]),
					.sw_wr(wr_latch),
					.sw_val(req.wdata[g]),
					.latch_bit(latch_q[g]),
					.active_bit(active_q[g])
				);
			end else begin : g_none
				assign latch_q[g] = 1'b0;
				assign active_q[g] = 1'b0;
			end
		end
	endgenerate

	// ==========================================================
	// read mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (asg_hit)
			rd_mux = assign_reg[asg_idx];
		else case (req.addr)
			sirq_pkg::OFF_MASK_LO: rd_mux = mask_lo_reg; // see [RULE7]
			sirq_pkg::OFF_MASK_HI: rd_mux = mask_hi_reg;
			sirq_pkg::OFF_STAT_LO: rd_mux = status[31:0];
			sirq_pkg::OFF_STAT_HI: rd_mux = status[63:32];
			sirq_pkg::OFF_WAKE_LO: rd_mux = wake_lo_reg;
			sirq_pkg::OFF_WAKE_HI: rd_mux = wake_hi_reg;
			sirq_pkg::OFF_LATCH: rd_mux = {16'h0000, latch_q}; // see [RULE11]
			sirq_pkg::OFF_CMASK: rd_mux = {15'h0000, gie_reg, cmask_reg};
			sirq_pkg::OFF_ACTIVE: rd_mux = {16'h0000, active_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// software registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_lo_reg <= sirq_pkg::MASK_RESET;
			mask_hi_reg <= sirq_pkg::MASK_RESET;
			wake_lo_reg <= sirq_pkg::WAKE_RESET;
			wake_hi_reg <= sirq_pkg::WAKE_RESET;
		end else begin
			if (wr_mask_lo)
				mask_lo_reg <= req.wdata;
			if (wr_mask_hi)
				mask_hi_reg <= req.wdata;
			if (wr_wake_lo)
				wake_lo_reg <= req.wdata;
			if (wr_wake_hi)
				wake_hi_reg <= req.wdata;
		end
	end

	// see [RULE3] see [RULE4] see [RULE5] see [RULE6]
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			assign_reg <= sirq_pkg::ASSIGN_RESET;
		end else if (wr_go && asg_hit) begin
			assign_reg[asg_idx] <= req.wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmask_reg <= sirq_pkg::CMASK_RESET;
		end else if (wr_cmask) begin
			cmask_reg <= req.wdata[15:0];
		end
	end

	// off wins when both instructions strike together
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gie_reg <= 1'b0;
		end else if (global_irq_off_instr) begin
			gie_reg <= 1'b0; // see [RULE15]
		end else if (global_irq_on_instr) begin
			gie_reg <= 1'b1;
		end
	end

	// ==========================================================
	// bus answer: one wait cycle, then data with waitrequest low
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_reg <= take_req;
			if (take_req)
				avs_readdata <= req.read ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~take_req;
		end
	end

	// ==========================================================
	// outputs to the core
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_req <= 1'b0;
			irq_req <= 1'b0;
			irq_level <= 4'h0;
		end else begin
			wake_req <= idle_s & (|wake_hit); // see [RULE10]
			irq_req <= win_any;
			irq_level <= win_level;
		end
	end
endmodule
`default_nettype wire

// ===== design/sirq_pkg.sv
package sirq_pkg;

	// ==========================================================
	// sizes
	localparam int NUM_IDS = 64;
	localparam int NUM_LEVELS = 9;
	localparam int EVT_W = 16;
	localparam int FIRST_LEVEL = 7;
	localparam int CODE_W = 4;
	localparam int IDS_PER_ASSIGN = 8;
	localparam int NUM_ASSIGN = 7;
	localparam int NUM_ROUTED = 56;

	// ==========================================================
	// register byte offsets
	localparam logic [5:0] OFF_MASK_LO = 6'h00;
	localparam logic [5:0] OFF_MASK_HI = 6'h04;
	localparam logic [5:0] OFF_STAT_LO = 6'h08;
	localparam logic [5:0] OFF_STAT_HI = 6'h0C;
	localparam logic [5:0] OFF_WAKE_LO = 6'h10;
	localparam logic [5:0] OFF_WAKE_HI = 6'h14;
	localparam logic [5:0] OFF_ASSIGN0 = 6'h18;
	localparam logic [5:0] OFF_LATCH = 6'h34;
	localparam logic [5:0] OFF_CMASK = 6'h38;
	localparam logic [5:0] OFF_ACTIVE = 6'h3C;

	// ==========================================================
	// reset values
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] WAKE_RESET = 32'h0000_0000;
	localparam logic [15:0] CMASK_RESET = 16'h0000;
	localparam logic [63:0] VALID_IDS = 64'h00F9_FFFF_7FFF_F7FF;
	// default core codes, one nibble per id, id 0 in the low nibble
	localparam logic [31:0] ASSIGN_RESET [NUM_ASSIGN] = '{
		32'h0000_0000,
		32'h2211_0000,
		32'h3333_2222,
		32'h0444_4433,
		32'h5555_5555,
		32'h0666_6655,
		32'h3333_3003
	};
	localparam logic [31:0] WAKE_REQ_BIT = 32'h0000_0001;

	typedef struct packed {
		logic [5:0] addr;
		logic read;
		logic write;
		logic [31:0] wdata;
	} sirq_req_t;

endpackage

// ===== design/sirq_edge_latch.sv
`timescale 1ns/1ns
`default_nettype none
// one core event: edge detect, latch, active tracking
module sirq_edge_latch (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic evt_in,
	input wire logic mask_bit,
	input wire logic gie,
	input wire logic grant,
	input wire logic retire,
	input wire logic sw_wr,
	input wire logic sw_val,
	output logic latch_bit,
	output logic active_bit
);
	logic prev_reg;
	logic edge_reg;
	logic latch_next;
	logic active_next;
	wire rise = evt_in & ~prev_reg;
	wire take = grant & latch_bit & mask_bit & gie;

	assign active_next = take ? 1'b1 : (retire ? 1'b0 : active_bit); // see [RULE16]
	always_comb begin
		latch_next = latch_bit;
		if (sw_wr && !mask_bit)
			latch_next = sw_val; // see [RULE13]
		if (take)
			latch_next = 1'b0; // see [RULE12]
		if (edge_reg)
			latch_next = 1'b1; // see [RULE17] see [RULE18]
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg <= 1'b0;
			edge_reg <= 1'b0;
			latch_bit <= 1'b0;
			active_bit <= 1'b0;
		end else begin
			prev_reg <= evt_in;
			edge_reg <= rise; // see [RULE12] see [RULE19]
			latch_bit <= latch_next;
			active_bit <= active_next;
		end
	end
endmodule
`default_nettype wire

// ===== design/sirq_sync.sv
`timescale 1ns/1ns
`default_nettype none
module sirq_sync #(
	parameter int W = 64
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ===== tb/sirq_router_properties.sv
`timescale 1ns/1ns
`default_nettype none
module sirq_router_properties (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [63:0] periph_irq,
	input wire logic core_idle,
	input wire logic global_irq_on_instr,
	input wire logic global_irq_off_instr,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic wake_req,
	input wire logic irq_req,
	input wire logic [3:0] irq_level
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_take;
		avs_waitrequest && (avs_read || avs_write);
	endsequence
	sequence s_off;
		global_irq_off_instr ##1 !global_irq_on_instr;
	endsequence
	// ==========================================================
	// register bus
	ans_next_a: assert property (s_take |=> !avs_waitrequest)
		else $error("bus answer not one cycle after request");
	ans_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer longer than one cycle");
	ans_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("bus answer without request");
	resv_lo_a: assert property (!avs_waitrequest && $past(avs_read && avs_address == sirq_pkg::OFF_STAT_LO) |-> (avs_readdata & ~sirq_pkg::VALID_IDS[31:0]) == 32'h0)
		else $error("reserved low status bit set");
	resv_hi_a: assert property (!avs_waitrequest && $past(avs_read && avs_address == sirq_pkg::OFF_STAT_HI) |-> (avs_readdata & ~sirq_pkg::VALID_IDS[63:32]) == 32'h0)
		else $error("reserved high status bit set");
	// ==========================================================
	// events
	wake_idle_a: assert property ((!core_idle)[*5] |=> !wake_req)
		else $error("wake request while core busy");
	wake_line_a: assert property ((periph_irq == 64'h0)[*5] |=> !wake_req)
		else $error("wake request with no live line");
	lvl_range_a: assert property (irq_req |-> irq_level >= 4'h7)
		else $error("request level outside general range");
	gie_off_a: assert property (s_off |=> !irq_req)
		else $error("request while globally disabled");
endmodule
`default_nettype wire

// ===== tb/sirq_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// core pipeline: takes a request when allowed, retires on command
module sirq_core_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic irq_req,
	input wire logic accept_en,
	input wire logic slow,
	input wire logic retire_go,
	input wire logic [3:0] retire_lvl,
	output logic pipe_accept,
	output logic [15:0] evt_retire
);
	logic req_d_reg;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_d_reg <= 1'h0;
			pipe_accept <= 1'h0;
			evt_retire <= 16'h0;
		end else begin
			req_d_reg <= irq_req;
			pipe_accept <= accept_en && (slow ? req_d_reg : irq_req);
			evt_retire <= retire_go ? 16'h1 << retire_lvl : 16'h0;
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb_system_interrupt_router.sv
`timescale 1ns/1ns
`default_nettype none
module tb_system_interrupt_router;
	logic sys_clk = 1'h0, rst_n = 1'h0;
	logic [63:0] periph_irq = 64'h0;
	logic core_idle = 1'h0, global_irq_on_instr = 1'h0, global_irq_off_instr = 1'h0;
	logic avs_read = 1'h0, avs_write = 1'h0, accept_en = 1'h0, slow = 1'h0, retire_go = 1'h0;
	logic [3:0] retire_lvl = 4'h0;
	logic [5:0] avs_address = 6'h00;
	logic [31:0] avs_writedata = 32'h0, rdata, avs_readdata;
	logic pipe_accept, avs_waitrequest, wake_req, irq_req;
	logic [15:0] evt_retire;
	logic [3:0] irq_level;
	int err_total = 0, num_checks = 0;
	int ids [10] = '{0, 12, 14, 20, 26, 32, 42, 47, 48, 55};
	logic [3:0] lv [10] = '{4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'h7, 4'hA, 4'hA};
	always #25 sys_clk = ~sys_clk;
	sirq_router uut (.*);
	sirq_core_model core (.*);
	// ==========================================================
	// helpers
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
		rdata = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask
	task rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0);
		chk(what, rdata, exp);
	endtask
	task wait_irq(input logic want);
		int n;
		n = 0;
		while (irq_req !== want && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		chk("irq_req", irq_req, want);
	endtask
	task gie(input logic on);
		@(posedge sys_clk);
		global_irq_on_instr <= on;
		global_irq_off_instr <= !on;
		@(posedge sys_clk);
		global_irq_on_instr <= 1'h0;
		global_irq_off_instr <= 1'h0;
	endtask
	task retire7;
		retire_lvl <= 4'h7;
		retire_go <= 1'h1;
		@(posedge sys_clk);
		retire_go <= 1'h0;
		repeat (6) @(posedge sys_clk);
	endtask
	// ==========================================================
	// scenarios
	task t_reset;
		for (int i = 0; i < 7; i++)
			rd_chk("assign", sirq_pkg::OFF_ASSIGN0 + 6'(4 * i), sirq_pkg::ASSIGN_RESET[i]);
		rd_chk("mask lo", sirq_pkg::OFF_MASK_LO, sirq_pkg::MASK_RESET);
		rd_chk("wake hi", sirq_pkg::OFF_WAKE_HI, sirq_pkg::WAKE_RESET);
		rd_chk("cmask", sirq_pkg::OFF_CMASK, 32'(sirq_pkg::CMASK_RESET));
		bus(1'h1, sirq_pkg::OFF_WAKE_HI, 32'hA5A5_5A5A);
		rd_chk("wake hi", sirq_pkg::OFF_WAKE_HI, 32'hA5A5_5A5A);
		bus(1'h1, sirq_pkg::OFF_WAKE_HI, 32'h0);
	endtask
	task t_status;
		periph_irq <= 64'hFFFF_FFFF_FFFF_FFFF;
		repeat (5) @(posedge sys_clk);
		rd_chk("stat lo", sirq_pkg::OFF_STAT_LO, sirq_pkg::VALID_IDS[31:0]);
		rd_chk("stat hi", sirq_pkg::OFF_STAT_HI, sirq_pkg::VALID_IDS[63:32]);
		periph_irq <= 64'h0;
		repeat (5) @(posedge sys_clk);
		rd_chk("stat lo", sirq_pkg::OFF_STAT_LO, 32'h0);
	endtask
	task t_route;
		bus(1'h1, sirq_pkg::OFF_CMASK, 32'h0000_FFFF);
		gie(1'h1);
		periph_irq <= 64'h8;
		repeat (10) @(posedge sys_clk);
		chk("blocked", irq_req, 1'h0);
		periph_irq <= 64'h0;
		bus(1'h1, sirq_pkg::OFF_MASK_LO, 32'hFFFF_FFFF);
		bus(1'h1, sirq_pkg::OFF_MASK_HI, 32'hFFFF_FFFF);
		for (int i = 0; i < 10; i++) begin
			periph_irq <= 64'h1 << ids[i];
			wait_irq(1'h1);
			chk("level", irq_level, lv[i]);
			periph_irq <= 64'h0;
			bus(1'h1, sirq_pkg::OFF_LATCH, 32'h0);
			rd_chk("latch", sirq_pkg::OFF_LATCH, 32'h1 << lv[i]);
			bus(1'h1, sirq_pkg::OFF_CMASK, 32'h0);
			wait_irq(1'h0);
			bus(1'h1, sirq_pkg::OFF_LATCH, 32'h0);
			rd_chk("latch", sirq_pkg::OFF_LATCH, 32'h0);
			bus(1'h1, sirq_pkg::OFF_CMASK, 32'h0000_FFFF);
		end
		bus(1'h1, sirq_pkg::OFF_ASSIGN0 + 6'h18, 32'h8333_3003);
		periph_irq <= 64'h0080_0000_0000_0000;
		wait_irq(1'h1);
		chk("level", irq_level, 4'hF);
		periph_irq <= 64'h0080_0000_0000_0001;
		repeat (8) @(posedge sys_clk);
		chk("level", irq_level, 4'h7);
		periph_irq <= 64'h0;
		bus(1'h1, sirq_pkg::OFF_CMASK, 32'h0);
		bus(1'h1, sirq_pkg::OFF_LATCH, 32'h0);
		bus(1'h1, sirq_pkg::OFF_CMASK, 32'h0000_FFFF);
	endtask
	task t_service;
		accept_en <= 1'h1;
		periph_irq <= 64'h1;
		rd_chk("active", sirq_pkg::OFF_ACTIVE, 32'h0);
		repeat (12) @(posedge sys_clk);
		rd_chk("active", sirq_pkg::OFF_ACTIVE, 32'h0080);
		rd_chk("latch", sirq_pkg::OFF_LATCH, 32'h0);
		periph_irq <= 64'h0;
		accept_en <= 1'h0;
		repeat (4) @(posedge sys_clk);
		periph_irq <= 64'h3;
		repeat (8) @(posedge sys_clk);
		rd_chk("latch", sirq_pkg::OFF_LATCH, 32'h0080);
		retire7;
		rd_chk("active", sirq_pkg::OFF_ACTIVE, 32'h0);
		slow <= 1'h1;
		accept_en <= 1'h1;
		repeat (14) @(posedge sys_clk);
		rd_chk("active", sirq_pkg::OFF_ACTIVE, 32'h0080);
		rd_chk("latch", sirq_pkg::OFF_LATCH, 32'h0);
		periph_irq <= 64'h0;
		accept_en <= 1'h0;
		slow <= 1'h0;
		retire7;
	endtask
	task t_wake;
		bus(1'h1, sirq_pkg::OFF_WAKE_LO, 32'h8);
		core_idle <= 1'h1;
		periph_irq <= 64'h10;
		repeat (8) @(posedge sys_clk);
		chk("wake", wake_req, 1'h0);
		periph_irq <= 64'h8;
		repeat (6) @(posedge sys_clk);
		chk("wake", wake_req, 1'h1);
		core_idle <= 1'h0;
		repeat (6) @(posedge sys_clk);
		chk("wake", wake_req, 1'h0);
		wait_irq(1'h1);
		gie(1'h0);
		wait_irq(1'h0);
		gie(1'h1);
		wait_irq(1'h1);
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#250000;
		err_total++;
		end_of_test;
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'h1;
		t_reset;
		t_status;
		t_route;
		t_service;
		t_wake;
		end_of_test;
	end
endmodule
bind sirq_router sirq_router_properties chk_i (.*);
`default_nettype wire
